// *** verilog/bar_pkg.sv ***
// constants and types shared by the asynchronous receive engine
package bar_pkg;

    // ******************************************
    // clock and timing
    // ******************************************
    localparam int          CLK_PERIOD_NS = 50;
    localparam int          NS_PER_US     = 1000;
    localparam int          US_PER_MS     = 1000;
    localparam logic [4:0]  CYC_PER_US    = 5'(NS_PER_US / CLK_PERIOD_NS);
    localparam int          MS_CYCLES     = US_PER_MS * NS_PER_US
                                            / CLK_PERIOD_NS;
    localparam logic [12:0] BIT_OFFSET_US = 13'h014;

    // ******************************************
    // line configuration word
    // ******************************************
    localparam int           CFG_PERIOD_MSB = 11;
    localparam int           CFG_PARITY_BIT = 13;
    localparam int           CFG_INVERT_BIT = 14;
    localparam logic [15:0]  CFG_9600_7E_INV = 16'h6054;

    // ******************************************
    // sizes and reset values
    // ******************************************
    localparam int          DATA_W      = 8;
    localparam int          INDEX_W     = 4;
    localparam int          ARRAY_DEPTH = 16;
    localparam int          SEQ_MAX     = 3;
    localparam int          FIFO_DEPTH  = 4;
    localparam int          FIFO_W      = INDEX_W + DATA_W;
    localparam logic [15:0] CFG_RESET   = 16'h0000;

    // ******************************************
    // types
    // ******************************************
    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_WAIT,
        MODE_STRING
    } bar_mode_t;

    typedef enum logic [1:0] {
        FR_IDLE,
        FR_START,
        FR_BITS,
        FR_STOP
    } bar_frame_t;

endpackage : bar_pkg

// *** verilog/bar_sync.sv ***
// two flip-flop synchroniser for one pin input
`timescale 1ns/100ps
module bar_sync
    import bar_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic pinIn,
    output logic      pinSync
);
    logic stage1;

    // idle mark level until the first real samples arrive
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            stage1  <= 1'b1;
            pinSync <= 1'b1;
        end
        else
        begin
            stage1  <= pinIn;
            pinSync <= stage1;
        end
    end

endmodule : bar_sync

// *** verilog/bar_fifo.sv ***
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/100ps
module bar_fifo
    import bar_pkg::*;
#(
    parameter int WIDTH = FIFO_W,
    parameter int DEPTH = FIFO_DEPTH
)(
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    logic             doWrite;
    logic             doRead;

    assign inReady  = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];
    assign doWrite  = inValid && inReady;
    assign doRead   = outValid && outReady;

    always_ff @(posedge core_clk)
    begin
        if (doWrite)
        begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end
        else
        begin
            if (doWrite)
                wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
            if (doRead)
                rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
            if (doWrite && !doRead)
                count <= count + 1'b1;
            else if (doRead && !doWrite)
                count <= count - 1'b1;
        end
    end

endmodule : bar_fifo

// *** verilog/bar_receiver.sv ***
// asynchronous serial receive engine with flow pin, sequence wait, strings
`timescale 1ns/100ps
module bar_receiver
    import bar_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES
)(
    input  wire logic                   core_clk,
    input  wire logic                   rst,
    input  wire logic [15:0]            lineConfig,
    input  wire logic                   opStart,
    input  wire logic [1:0]             opMode,
    input  wire logic                   flowEnable,
    input  wire logic [15:0]            timeoutMs,
    input  wire logic [1:0]             seqLen,
    input  wire logic [SEQ_MAX*8-1:0]   seqChars,
    input  wire logic [INDEX_W-1:0]     strLen,
    input  wire logic                   rxPinIn,
    output logic                        rxPinOut,
    output logic                        rxPinOe,
    output logic                        flowPinOut,
    output logic                        flowPinOe,
    output logic                        busy,
    output logic                        doneOk,
    output logic                        parityFail,
    output logic                        timeoutFail,
    output logic                        overrun,
    output logic [INDEX_W:0]            byteCount,
    output logic                        outValid,
    input  wire logic                   outReady,
    output logic [DATA_W-1:0]           outData,
    output logic [INDEX_W-1:0]          outIndex
);
    localparam int PW = $clog2(MS_CYCLES_P + 1);

    // ******************************************
    // latched operation settings
    // ******************************************
    bar_mode_t         mode;
    logic              parityMode;
    logic              polInv;
    logic              flowOn;
    logic [17:0]       bitCycles;
    logic [15:0]       tmoLimit;
    logic [1:0]        seqTarget;
    logic [7:0]        seqLatched [SEQ_MAX];
    logic [INDEX_W:0]  strLimit;

    // ******************************************
    // frame and operation state
    // ******************************************
    bar_frame_t        frState;
    logic              rxSync;
    logic              rxLine;
    logic              rxPrev;
    logic [17:0]       bitTimer;
    logic [2:0]        bitIdx;
    logic [7:0]        shiftReg;
    logic              byteDone;
    logic              startEdge;
    logic              parityBad;
    logic [7:0]        byteValue;
    logic [1:0]        seqIdx;
    logic              seqWaiting;
    logic              tmoRunning;
    logic [PW-1:0]     msPre;
    logic [15:0]       msCount;
    logic              tmoHit;
    logic              pushValid;
    logic              pushReady;
    logic              launch;
    logic [FIFO_W-1:0] popData;

    // next sequence position after one byte; a miss may restart the match
    function automatic logic [1:0] nextSeqIdx(
        input logic [1:0] idx,
        input logic [7:0] b,
        input logic [7:0] c0,
        input logic [7:0] cIdx
    );
        if (b == cIdx)
            return idx + 2'h1;
        else if (b == c0)
            return 2'h1;
        else
            return 2'h0;
    endfunction : nextSeqIdx

    bar_sync u_rxSync (
        .core_clk (core_clk),
        .rst      (rst),
        .pinIn    (rxPinIn),
        .pinSync  (rxSync)
    );

    // ******************************************
    // settings captured at launch
    // ******************************************
    assign launch = opStart && !busy;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            mode       <= MODE_SINGLE;
            parityMode <= CFG_RESET[CFG_PARITY_BIT];
            polInv     <= CFG_RESET[CFG_INVERT_BIT];
            flowOn     <= 1'b0;
            bitCycles  <= '0;
            tmoLimit   <= '0;
            seqTarget  <= '0;
            strLimit   <= '0;
        end
        else if (launch)
        begin
            // illegal mode code falls back to a single byte
            mode       <= (opMode == 2'h3) ? MODE_SINGLE : bar_mode_t'(opMode);
            parityMode <= lineConfig[CFG_PARITY_BIT];
            polInv     <= lineConfig[CFG_INVERT_BIT];
            flowOn     <= flowEnable;
            bitCycles  <= 18'(18'({1'b0, lineConfig[CFG_PERIOD_MSB:0]})
                              + 18'(BIT_OFFSET_US)) * 18'(CYC_PER_US);
            tmoLimit   <= timeoutMs;
            seqTarget  <= seqLen;
            strLimit   <= (strLen == '0) ? (INDEX_W+1)'(ARRAY_DEPTH)
                                         : {1'b0, strLen};
        end
    end

    generate
        for (genvar g = 0; g < SEQ_MAX; g++)
        begin : g_seq
            always_ff @(posedge core_clk)
            begin
                if (rst)
                    seqLatched[g] <= '0;
                else if (launch)
                    seqLatched[g] <= seqChars[g*8 +: 8];
            end
        end
    endgenerate

    // ******************************************
    // frame sampling
    // ******************************************
    assign rxLine    = rxSync ^ polInv;
    assign startEdge = busy && frState == FR_IDLE && rxPrev && !rxLine;
    assign parityBad = parityMode && (^shiftReg);
    assign byteValue = parityMode ? {1'b0, shiftReg[6:0]} : shiftReg;

    always_ff @(posedge core_clk)
    begin
        if (rst)
            rxPrev <= 1'b1;
        else
            rxPrev <= rxLine;
    end

    // only runs while an operation is open, so stray bytes vanish
    always_ff @(posedge core_clk)
    begin
        byteDone <= 1'b0;
        if (rst || !busy)
        begin
            frState  <= FR_IDLE;
            bitTimer <= '0;
            bitIdx   <= '0;
            shiftReg <= '0;
        end
        else
        begin
            unique case (frState)
                FR_IDLE:
                    if (startEdge)
                    begin
                        frState  <= FR_START;
                        bitTimer <= bitCycles >> 1;
                    end
                FR_START:
                    if (bitTimer != '0)
                        bitTimer <= bitTimer - 1'b1;
                    else if (rxLine)
                        frState <= FR_IDLE;
                    else
                    begin
                        frState  <= FR_BITS;
                        bitTimer <= bitCycles - 1'b1;
                        bitIdx   <= '0;
                    end
                FR_BITS:
                    if (bitTimer != '0)
                        bitTimer <= bitTimer - 1'b1;
                    else
                    begin
                        shiftReg <= {rxLine, shiftReg[7:1]};
                        bitIdx   <= bitIdx + 1'b1;
                        bitTimer <= bitCycles - 1'b1;
                        if (bitIdx == 3'h7)
                            frState <= FR_STOP;
                    end
                FR_STOP:
                    if (bitTimer != '0)
                        bitTimer <= bitTimer - 1'b1;
                    else
                    begin
                        frState  <= FR_IDLE;
                        byteDone <= 1'b1;
                    end
            endcase
        end
    end

    // ******************************************
    // timeout
    // ******************************************
    assign tmoHit = tmoRunning && msCount == tmoLimit;

    always_ff @(posedge core_clk)
    begin
        if (rst || launch)
        begin
            tmoRunning <= launch && timeoutMs != '0;
            msPre      <= '0;
            msCount    <= '0;
        end
        else if (startEdge || tmoHit || !busy)
            tmoRunning <= 1'b0;
        else if (tmoRunning)
        begin
            if (msPre == PW'(MS_CYCLES_P - 1))
            begin
                msPre   <= '0;
                msCount <= msCount + 1'b1;
            end
            else
                msPre <= msPre + 1'b1;
        end
    end

    // ******************************************
    // operation control
    // ******************************************
    assign seqWaiting = mode == MODE_WAIT && seqIdx != seqTarget;
    assign pushValid  = busy && byteDone && !parityBad && !seqWaiting;

    always_ff @(posedge core_clk)
    begin
        doneOk      <= 1'b0;
        parityFail  <= 1'b0;
        timeoutFail <= 1'b0;
        if (rst)
        begin
            busy      <= 1'b0;
            seqIdx    <= '0;
            byteCount <= '0;
            overrun   <= 1'b0;
        end
        else if (launch)
        begin
            busy      <= 1'b1;
            seqIdx    <= '0;
            byteCount <= '0;
            overrun   <= 1'b0;
        end
        else if (busy)
        begin
            if (tmoHit)
            begin
                busy        <= 1'b0;
                timeoutFail <= 1'b1;
            end
            else if (byteDone && parityBad)
            begin
                busy       <= 1'b0;
                parityFail <= 1'b1;
            end
            else if (byteDone && seqWaiting)
                seqIdx <= nextSeqIdx(seqIdx, byteValue, seqLatched[0],
                                     seqLatched[seqIdx]);
            else if (pushValid)
            begin
                byteCount <= byteCount + 1'b1;
                if (!pushReady)
                    overrun <= 1'b1;
                if (mode != MODE_STRING || byteCount + 1'b1 == strLimit)
                begin
                    busy   <= 1'b0;
                    doneOk <= 1'b1;
                end
            end
        end
    end

    // ******************************************
    // flow pin and receive pin direction
    // ******************************************
    assign rxPinOut = 1'b0;
    assign rxPinOe  = 1'b0;

    // go only while room remains, so the sender is held off when full
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            flowPinOut <= 1'b0;
            flowPinOe  <= 1'b0;
        end
        else
        begin
            if (launch && flowEnable)
                flowPinOe <= 1'b1;
            if (busy && pushReady)
                flowPinOut <= polInv;
            else
                flowPinOut <= ~polInv;
        end
    end

    bar_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst      (rst),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .inData   ({byteCount[INDEX_W-1:0], byteValue}),
        .outValid (outValid),
        .outReady (outReady),
        .outData  (popData)
    );

    assign outIndex = popData[FIFO_W-1:DATA_W];
    assign outData  = popData[DATA_W-1:0];

    // ******************************************
    // checks
    // ******************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    property p_parityAbort;
        busy && byteDone && parityBad && !tmoHit |=> parityFail && !busy;
    endproperty
    a_parityAbort: assert property (p_parityAbort)
        else $error("parity mismatch did not abort");

    property p_noTimeout;
        busy && tmoLimit == '0 |=> !timeoutFail;
    endproperty
    a_noTimeout: assert property (p_noTimeout)
        else $error("timeout fired with no limit");

    property p_timeoutExit;
        busy && tmoHit |=> timeoutFail && !busy && !parityFail;
    endproperty
    a_timeoutExit: assert property (p_timeoutExit)
        else $error("timeout exit missing");

    property p_exclusive;
        busy && opStart |=> $stable(mode) && $stable(bitCycles);
    endproperty
    a_exclusive: assert property (p_exclusive)
        else $error("second operation disturbed the first");

    property p_flowGo;
        busy && pushReady |=> flowPinOut == polInv;
    endproperty
    a_flowGo: assert property (p_flowGo)
        else $error("flow pin not at go level");

    // polarity as it stood when the stop level was registered
    property p_flowStop;
        busy ##1 !busy |=> flowPinOut == !$past(polInv);
    endproperty
    a_flowStop: assert property (p_flowStop)
        else $error("flow pin not stop after finish");

    property p_seqHold;
        busy && byteDone && seqWaiting && !parityBad
            |=> busy && !doneOk && $stable(byteCount);
    endproperty
    a_seqHold: assert property (p_seqHold)
        else $error("byte captured before sequence matched");

    property p_strCount;
        doneOk && mode == MODE_STRING |-> byteCount == strLimit;
    endproperty
    a_strCount: assert property (p_strCount)
        else $error("string length wrong at finish");

    property p_timerFreeze;
        startEdge |=> !tmoRunning ##1 $stable(msCount);
    endproperty
    a_timerFreeze: assert property (p_timerFreeze)
        else $error("timeout kept running after start bit");

    property p_halfBit;
        frState == FR_IDLE && startEdge |=> bitTimer == (bitCycles >> 1);
    endproperty
    a_halfBit: assert property (p_halfBit)
        else $error("start bit not centred");

endmodule : bar_receiver

// *** tb/bar_sender_model.sv ***
// behavioural serial sender that honours the receiver's flow pin
`timescale 1ns/100ps
module bar_sender_model (
    input  wire logic        core_clk,
    input  wire logic        flowPin,
    input  wire logic        flowUse,
    input  wire logic        invert,
    input  wire logic [15:0] bitCycles,
    output logic             txLine
);
    // ****************************************
    // line driver
    // ****************************************
    logic sending = 1'b0;
    logic lineBit = 1'b1;

    // between frames the line rests at mark, never at a stale data level
    assign txLine = sending ? (lineBit ^ invert) : ~invert;

    task send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        // sample the flow pin away from the edge that updates it
        @(negedge core_clk);
        while (flowUse && flowPin !== invert)
            @(negedge core_clk);
        for (int i = 0; i < 10; i++)
        begin
            @(posedge core_clk);
            sending <= 1'b1;
            lineBit <= frame[i];
            repeat (bitCycles - 16'd1) @(posedge core_clk);
        end
        @(posedge core_clk);
        sending <= 1'b0;
    endtask : send_byte
endmodule : bar_sender_model

// *** tb/bar_receiver_tb.sv ***
// self-checking bench for the asynchronous receive engine
`timescale 1ns/100ps
module bar_receiver_tb;
    // ****************************************
    // signals and instances
    // ****************************************
    logic        core_clk, rst, opStart, flowEnable, outReady, rxLine;
    logic        flowPinOut, flowPinOe, busy, doneOk, parityFail;
    logic        timeoutFail, overrun, outValid, flowWire, senderFlow;
    logic        rxOut, rxOe;
    logic [15:0] lineConfig, timeoutMs, bitCycles;
    logic [1:0]  opMode, seqLen;
    logic [23:0] seqChars;
    logic [3:0]  strLen, outIndex;
    logic [4:0]  byteCount;
    logic [7:0]  outData;
    logic [2:0]  ex;
    int          miscompares = 0;
    int          checkCount = 0;
    int          cycles = 0;
    int          waited;

    // flow line has a resistor to the stop level while undriven
    assign flowWire  = flowPinOe ? flowPinOut : ~lineConfig[14];
    assign bitCycles = (16'(lineConfig[11:0]) + 16'd20) * 16'd20;

    bar_receiver #(.MS_CYCLES_P(20)) dut (
        .core_clk(core_clk), .rst(rst), .lineConfig(lineConfig),
        .opStart(opStart), .opMode(opMode), .flowEnable(flowEnable),
        .timeoutMs(timeoutMs), .seqLen(seqLen), .seqChars(seqChars),
        .strLen(strLen), .rxPinIn(rxLine), .rxPinOut(rxOut), .rxPinOe(rxOe),
        .flowPinOut(flowPinOut), .flowPinOe(flowPinOe), .busy(busy),
        .doneOk(doneOk), .parityFail(parityFail),
        .timeoutFail(timeoutFail), .overrun(overrun),
        .byteCount(byteCount), .outValid(outValid), .outReady(outReady),
        .outData(outData), .outIndex(outIndex)
    );

    bar_sender_model sender (
        .core_clk(core_clk), .flowPin(flowWire), .flowUse(senderFlow),
        .invert(lineConfig[14]), .bitCycles(bitCycles), .txLine(rxLine)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task test_done;
        $display("checks %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done

    task automatic launch(input logic [15:0] cfg, input logic [1:0] mode,
                          input logic flow, input logic [15:0] tmo);
        @(posedge core_clk);
        lineConfig <= cfg;
        opMode     <= mode;
        flowEnable <= flow;
        timeoutMs  <= tmo;
        repeat (5) @(posedge core_clk);
        opStart <= 1'b1;
        @(posedge core_clk);
        opStart <= 1'b0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
    endtask : launch

    task automatic wait_exit(input int limit);
        ex = 3'b000;
        for (waited = 0; waited < limit && ex === 3'b000; waited++)
        begin
            @(negedge core_clk);
            ex = {timeoutFail, parityFail, doneOk};
        end
    endtask : wait_exit

    task automatic frame_exit(input logic [7:0] b, input logic [2:0] exp);
        fork
            sender.send_byte(b);
        join_none
        wait_exit(30000);
        check("exit", 16'(ex), 16'(exp));
        wait fork;
    endtask : frame_exit

    task automatic pop(input logic [7:0] m, input logic [7:0] d,
                       input logic [3:0] idx);
        @(negedge core_clk);
        check("outValid", 16'(outValid), 16'h0001);
        check("outData", 16'(outData & m), 16'(d & m));
        check("outIndex", 16'(outIndex), 16'(idx));
        @(posedge core_clk);
        outReady <= 1'b1;
        @(posedge core_clk);
        outReady <= 1'b0;
    endtask : pop

    // ****************************************
    // scenarios
    // ****************************************
    task test_idle_lost;
        sender.send_byte(8'h5a);
        repeat (10) @(negedge core_clk);
        check("idleValid", 16'(outValid), 16'h0000);
        check("idleCount", 16'(byteCount), 16'h0000);
    endtask : test_idle_lost

    task test_single_flow;
        launch(16'h0000, 2'd0, 1'b1, 16'h0000);
        check("flowGo", 16'(flowWire), 16'h0000);
        check("rxPinDir", 16'({rxOut, rxOe}), 16'h0000);
        repeat (300) @(negedge core_clk);
        check("busyWaits", 16'(busy), 16'h0001);
        senderFlow = 1'b1;
        frame_exit(8'hc3, 3'b001);
        check("flowStop", 16'(flowWire), 16'h0001);
        pop(8'hff, 8'hc3, 4'h0);
        senderFlow = 1'b0;
    endtask : test_single_flow

    task test_9600_inverted;
        // mode code 3 is taken as a single byte
        launch(16'h6054, 2'd3, 1'b1, 16'h0000);
        check("flowGoInv", 16'(flowWire), 16'h0001);
        frame_exit(8'h41, 3'b001);
        check("flowStopInv", 16'(flowWire), 16'h0000);
        pop(8'h7f, 8'h41, 4'h0);
    endtask : test_9600_inverted

    task test_parity_abort;
        // a 1 ms limit would expire mid-frame unless the start bit stops it
        launch(16'h6000, 2'd0, 1'b0, 16'h0001);
        frame_exit(8'h43, 3'b010);
        check("noCapture", 16'(outValid), 16'h0000);
    endtask : test_parity_abort

    task test_timeout;
        launch(16'h6000, 2'd0, 1'b0, 16'h0002);
        wait_exit(300);
        check("timeoutExit", 16'(ex), 16'h0004);
        check("timeoutSpan", 16'(waited > 30 && waited < 50), 16'h0001);
    endtask : test_timeout

    task test_seq_wait;
        @(posedge core_clk);
        seqLen   <= 2'd2;
        seqChars <= 24'h005958;
        launch(16'h0000, 2'd1, 1'b0, 16'h0000);
        // a second start while busy must not turn this into a string
        @(posedge core_clk);
        opMode  <= 2'd2;
        opStart <= 1'b1;
        @(posedge core_clk);
        opStart <= 1'b0;
        @(negedge core_clk);
        check("refusedBusy", 16'(busy), 16'h0001);
        sender.send_byte(8'h58);
        sender.send_byte(8'h58);
        sender.send_byte(8'h59);
        check("seqDiscard", 16'(outValid), 16'h0000);
        frame_exit(8'h44, 3'b001);
        pop(8'hff, 8'h44, 4'h0);
    endtask : test_seq_wait

    task test_string_fill;
        @(posedge core_clk);
        strLen <= 4'h5;
        launch(16'h0000, 2'd2, 1'b1, 16'h0000);
        senderFlow = 1'b1;
        fork
            for (int k = 0; k < 5; k++)
                sender.send_byte(8'h30 + 8'(k));
        join_none
        for (int i = 0; i < 20000 && byteCount !== 5'h04; i++)
            @(negedge core_clk);
        repeat (1000) @(negedge core_clk);
        check("fullStall", 16'(byteCount), 16'h0004);
        check("fullStop", 16'(flowWire), 16'h0001);
        check("noOverrun", 16'(overrun), 16'h0000);
        for (int k = 0; k < 4; k++)
            pop(8'hff, 8'h30 + 8'(k), 4'(k));
        wait_exit(30000);
        check("strExit", 16'(ex), 16'h0001);
        pop(8'hff, 8'h34, 4'h4);
        check("strCount", 16'(byteCount), 16'h0005);
        wait fork;
        senderFlow = 1'b0;
    endtask : test_string_fill

    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 90000)
        begin
            miscompares++;
            test_done();
        end
    end

    initial
    begin
        rst        = 1'b1;
        lineConfig = 16'h0000;
        opStart    = 1'b0;
        opMode     = 2'd0;
        flowEnable = 1'b0;
        timeoutMs  = 16'h0000;
        seqLen     = 2'd0;
        seqChars   = 24'h000000;
        strLen     = 4'h0;
        outReady   = 1'b0;
        senderFlow = 1'b0;
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        repeat (5) @(posedge core_clk);
        test_idle_lost();
        test_single_flow();
        test_9600_inverted();
        test_parity_abort();
        test_timeout();
        test_seq_wait();
        test_string_fill();
        test_done();
    end
endmodule : bar_receiver_tb
